//--- rtl/cec_exec.sv
// Chosen here: the plain strobed port and the address map.
module cec_exec
  import cec_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  // Instruction stream
  input  wire logic                          insnValid,
  input  wire logic [31:0]                   insn,
  output logic                               insnReady,
  output logic [cec_pkg::XLEN-1:0]           pc,
  // Memory access path
  output logic                               memRd,
  output logic                               memWr,
  output logic                               memByte,
  output logic [cec_pkg::XLEN-1:0]           memAddr,
  output logic [15:0]                        memWdata,
  input  wire logic [15:0]                   memRdata,
  // Software register port
  input  wire logic [cec_pkg::SW_AW-1:0]     swAddr,
  input  wire logic [cec_pkg::XLEN-1:0]      swWdata,
  input  wire logic                          swWr,
  input  wire logic                          swRd,
  output logic [cec_pkg::XLEN-1:0]           swRdata
);
  import cec_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] gr_r [32];
  logic [31:0] pc_r, pc_nxt, psw_r, psw_nxt;
  logic [31:0] table_call_return_pc_r, table_call_return_pc_nxt, table_call_saved_status_r, table_call_saved_status_nxt, table_call_base_r, table_call_base_nxt;
  logic [31:0] debug_return_pc_r, debug_return_pc_nxt, debug_saved_status_r, debug_saved_status_nxt;
  logic [31:0] memAddr_r, memAddr_nxt, swRdata_r, swRdata_nxt;
  logic [15:0] memWdata_r, memWdata_nxt;
  logic        memRd_r, memRd_nxt, memWr_r, memWr_nxt, memByte_r, memByte_nxt;
  logic [2:0]  cnt_r, cnt_nxt, bit_r, bit_nxt;
  logic        ready_r, ready_nxt;
  cec_state_t  state_r, state_nxt;

  // Decode fields and datapath helpers
  logic [15:0] hw0, hw1;
  logic [5:0]  op;
  logic [4:0]  r1, r2, r3;
  logic [31:0] a1, a2, wrData;
  logic [4:0]  wrIdx;
  logic        wrEn, accept, condTake, flagArith, flagLogic, flagSwap;
  logic [3:0]  condCode;
  logic [7:0]  rdByte;

  cec_alu_if aluIf ();

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  cec_alu u_alu (
    .io (aluIf.alu)
  );

  cec_cond_eval u_cond (
    .cond  (condCode),
    .flags (psw_r[4:0]),
    .take  (condTake)
  );

  // Field extraction
  always_comb begin
    hw0      = insn[15:0];
    hw1      = insn[31:16];
    op       = hw0[10:5];
    r1       = hw0[4:0];
    r2       = hw0[15:11];
    r3       = hw1[15:11];
    a1       = gr_r[r1];
    a2       = gr_r[r2];
    accept   = insnValid && ready_r;
    rdByte   = memRdata[7:0];
    condCode = (op[5:2] == OP_BCOND) ? hw0[3:0] : hw1[4:1];
  end

  // ----------------------------------------------------------------
  // Execute: next values of all state except the general registers
  // ----------------------------------------------------------------
  always_comb begin
    pc_nxt       = pc_r;
    psw_nxt      = psw_r;
    table_call_return_pc_nxt     = table_call_return_pc_r;
    table_call_saved_status_nxt    = table_call_saved_status_r;
    table_call_base_nxt     = table_call_base_r;
    debug_return_pc_nxt     = debug_return_pc_r;
    debug_saved_status_nxt    = debug_saved_status_r;
    memAddr_nxt  = memAddr_r;
    memWdata_nxt = memWdata_r;
    memByte_nxt  = memByte_r;
    memRd_nxt    = 1'b0;
    memWr_nxt    = 1'b0;
    bit_nxt      = bit_r;
    state_nxt    = state_r;
    cnt_nxt      = (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;
    wrEn         = 1'b0;
    wrIdx        = r2;
    wrData       = aluIf.res;
    flagArith    = 1'b0;
    flagLogic    = 1'b0;
    flagSwap     = 1'b0;
    aluIf.a      = a2;
    aluIf.b      = a1;
    aluIf.op     = ALU_ADD;
    swRdata_nxt  = swRdata_r;

    // Software port read, answered one cycle later
    if (swRd) begin
      if (swAddr < SW_PSW) swRdata_nxt = gr_r[swAddr[4:0]];
      else if (swAddr == SW_PSW) swRdata_nxt = psw_r;
      else if (swAddr == SW_PC) swRdata_nxt = pc_r;
      else if (swAddr == SW_TABLE_CALL_RETURN_PC) swRdata_nxt = table_call_return_pc_r;
      else if (swAddr == SW_TABLE_CALL_SAVED_STATUS) swRdata_nxt = table_call_saved_status_r;
      else if (swAddr == SW_TABLE_CALL_BASE) swRdata_nxt = table_call_base_r;
      else if (swAddr == SW_DEBUG_RETURN_PC) swRdata_nxt = debug_return_pc_r;
      else if (swAddr == SW_DEBUG_SAVED_STATUS) swRdata_nxt = debug_saved_status_r;
      else swRdata_nxt = 32'h0000_0000;
    end

    // Software port write; execution below overrides it
    if (swWr) begin
      if (swAddr == SW_PSW) psw_nxt = swWdata;
      else if (swAddr == SW_PC) pc_nxt = swWdata;
      else if (swAddr == SW_TABLE_CALL_RETURN_PC) table_call_return_pc_nxt = swWdata;
      else if (swAddr == SW_TABLE_CALL_SAVED_STATUS) table_call_saved_status_nxt = swWdata;
      else if (swAddr == SW_TABLE_CALL_BASE) table_call_base_nxt = swWdata;
      else if (swAddr == SW_DEBUG_RETURN_PC) debug_return_pc_nxt = swWdata;
      else if (swAddr == SW_DEBUG_SAVED_STATUS) debug_saved_status_nxt = swWdata;
    end

    // Memory sequences of table call and bit clear
    case (state_r)
      ST_CT_ADDR: state_nxt = ST_CT_DATA;
      ST_CT_DATA: begin
        pc_nxt    = table_call_base_r + {16'h0000, memRdata};
        state_nxt = ST_RUN;
      end
      ST_BC_ADDR: state_nxt = ST_BC_DATA;
      ST_BC_DATA: begin
        psw_nxt[FLG_Z] = ~rdByte[bit_r];
        memWdata_nxt   = {8'h00, rdByte & ~(8'h01 << bit_r)};
        memWr_nxt      = 1'b1;
        state_nxt      = ST_RUN;
      end
      default: begin
      end
    endcase

    // Decode and execute an accepted instruction
    if (accept) begin
      pc_nxt = pc_r + 32'h0000_0002;
      if (op == OP_ADD_R || op == OP_ADD_I5 || op == OP_ADD_IMMEDIATE16) begin
        flagArith = 1'b1;
        wrEn      = 1'b1;
        if (op == OP_ADD_I5) aluIf.b = {{27{r1[4]}}, r1};
        if (op == OP_ADD_IMMEDIATE16) begin
          aluIf.a = a1;
          aluIf.b = {{16{hw1[15]}}, hw1};
          pc_nxt  = pc_r + 32'h0000_0004;
        end
      end else if (op == OP_CMP_R || op == OP_CMP_I5) begin
        aluIf.op  = ALU_SUB;
        flagArith = 1'b1;
        if (op == OP_CMP_I5) aluIf.b = {{27{r1[4]}}, r1};
      end else if (op == OP_AND_R || op == OP_AND_IMMEDIATE16) begin
        aluIf.op  = ALU_AND;
        flagLogic = 1'b1;
        wrEn      = 1'b1;
        if (op == OP_AND_IMMEDIATE16) begin
          aluIf.a = a1;
          aluIf.b = {16'h0000, hw1};
          pc_nxt  = pc_r + 32'h0000_0004;
        end
      end else if (op[5:2] == OP_BCOND) begin
        if (condTake) begin
          pc_nxt  = pc_r + {{23{hw0[15]}}, hw0[15:11], hw0[6:4], 1'b0};
          cnt_nxt = BUSY_BR;
        end
      end else if (hw0[15:6] == OP_TABLE_CALL) begin
        table_call_return_pc_nxt    = pc_r + 32'h0000_0002;
        table_call_saved_status_nxt   = psw_r;
        memAddr_nxt = table_call_base_r + {25'h000_0000, hw0[5:0], 1'b0};
        memByte_nxt = 1'b0;
        memRd_nxt   = 1'b1;
        state_nxt   = ST_CT_ADDR;
        cnt_nxt     = BUSY_TABLE_CALL;
      end else if (op == OP_CLR1I && hw0[15:14] == CLR1I_TOP) begin
        memAddr_nxt = a1 + {{16{hw1[15]}}, hw1};
        pc_nxt      = pc_r + 32'h0000_0004;
        bit_nxt     = hw0[13:11];
      end else if (op == OP_EXT) begin
        pc_nxt = pc_r + 32'h0000_0004;
        if (hw1[10:0] == SUB_BSH || hw1[10:0] == SUB_BSW) begin
          aluIf.a  = a2;
          aluIf.op = (hw1[10:0] == SUB_BSH) ? ALU_BSH : ALU_BSW;
          flagSwap = 1'b1;
          wrEn     = 1'b1;
          wrIdx    = r3;
        end else if ((hw1[10:5] == SUB_CMOVR || hw1[10:5] == SUB_CMOVI) && !hw1[0]) begin
          wrEn   = 1'b1;
          wrIdx  = r3;
          wrData = a2;
          if (condTake) begin
            wrData = (hw1[10:5] == SUB_CMOVR) ? a1 : {{27{r1[4]}}, r1};
          end
        end else if (hw1 == HW1_CLR1R) begin
          memAddr_nxt = a1;
          bit_nxt     = a2[2:0];
        end else if (hw0 == HW0_RET && hw1 == HW1_TABLE_CALL_RETURN) begin
          pc_nxt  = table_call_return_pc_r;
          psw_nxt = table_call_saved_status_r;
          cnt_nxt = BUSY_RET;
        end else if (hw0 == HW0_RET && hw1 == HW1_DEBUG_RETURN) begin
          pc_nxt  = debug_return_pc_r;
          psw_nxt = debug_saved_status_r;
          cnt_nxt = BUSY_RET;
        end
      end
      // Both bit clear forms start a byte read-modify-write
      if ((op == OP_CLR1I && hw0[15:14] == CLR1I_TOP) || (op == OP_EXT && hw1 == HW1_CLR1R)) begin
        memByte_nxt = 1'b1;
        memRd_nxt   = 1'b1;
        state_nxt   = ST_BC_ADDR;
        cnt_nxt     = BUSY_BIT_CLEAR;
      end
    end

    // Flag updates; bit clear sets Z in ST_BC_DATA and the returns reload the status word
    if (flagArith || flagLogic || flagSwap) begin
      psw_nxt[FLG_Z] = (aluIf.res == 32'h0000_0000);
      psw_nxt[FLG_S] = aluIf.res[31];
      psw_nxt[FLG_OV] = flagArith ? aluIf.ov : 1'b0;
      if (!flagLogic) psw_nxt[FLG_CY] = aluIf.cy;
    end
    ready_nxt = (cnt_nxt == 3'h0);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_r       <= PC_RST;
      psw_r      <= PSW_RST;
      table_call_return_pc_r     <= 32'h0000_0000;
      table_call_saved_status_r    <= 32'h0000_0000;
      table_call_base_r     <= 32'h0000_0000;
      debug_return_pc_r     <= 32'h0000_0000;
      debug_saved_status_r    <= 32'h0000_0000;
      memAddr_r  <= 32'h0000_0000;
      memWdata_r <= 16'h0000;
      memRd_r    <= 1'b0;
      memWr_r    <= 1'b0;
      memByte_r  <= 1'b0;
      bit_r      <= 3'h0;
      cnt_r      <= 3'h0;
      ready_r    <= 1'b1;
      state_r    <= ST_RUN;
      swRdata_r  <= 32'h0000_0000;
    end else begin
      pc_r       <= pc_nxt;
      psw_r      <= psw_nxt;
      table_call_return_pc_r     <= table_call_return_pc_nxt;
      table_call_saved_status_r    <= table_call_saved_status_nxt;
      table_call_base_r     <= table_call_base_nxt;
      debug_return_pc_r     <= debug_return_pc_nxt;
      debug_saved_status_r    <= debug_saved_status_nxt;
      memAddr_r  <= memAddr_nxt;
      memWdata_r <= memWdata_nxt;
      memRd_r    <= memRd_nxt;
      memWr_r    <= memWr_nxt;
      memByte_r  <= memByte_nxt;
      bit_r      <= bit_nxt;
      cnt_r      <= cnt_nxt;
      ready_r    <= ready_nxt;
      state_r    <= state_nxt;
      swRdata_r  <= swRdata_nxt;
    end
  end

  // General registers; r0 stays zero, execution wins over software
  generate
    for (genvar g = 0; g < 32; g++) begin : gen_gr
      always_ff @(posedge clk) begin
        if (srst || g == 0) begin
          gr_r[g] <= 32'h0000_0000;
        end else if (accept && wrEn && wrIdx == 5'(g)) begin
          gr_r[g] <= wrData;
        end else if (swWr && swAddr == 6'(g)) begin
          gr_r[g] <= swWdata;
        end
      end
    end
  endgenerate

  // Outputs straight from flip-flops
  assign insnReady = ready_r;
  assign pc        = pc_r;
  assign memRd     = memRd_r;
  assign memWr     = memWr_r;
  assign memByte   = memByte_r;
  assign memAddr   = memAddr_r;
  assign memWdata  = memWdata_r;
  assign swRdata   = swRdata_r;
endmodule : cec_exec

//--- rtl/cec_pkg.sv
package cec_pkg;
  // ----------------------------------------------------------------
  // Widths and status word layout
  // ----------------------------------------------------------------
  localparam int          XLEN     = 32;
  localparam int          SW_AW    = 6;
  localparam int          CNT_W    = 3;
  localparam int          FLG_Z    = 0;
  localparam int          FLG_S    = 1;
  localparam int          FLG_OV   = 2;
  localparam int          FLG_CY   = 3;
  localparam int          FLG_SAT  = 4;
  localparam logic [31:0] PSW_RST  = 32'h0000_0000;
  localparam logic [31:0] PC_RST   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Opcode fields (first halfword bits 10:5 unless noted)
  // ----------------------------------------------------------------
  localparam logic [5:0]  OP_ADD_R  = 6'h0E;
  localparam logic [5:0]  OP_ADD_I5 = 6'h12;
  localparam logic [5:0]  OP_ADD_IMMEDIATE16   = 6'h30;
  localparam logic [5:0]  OP_AND_R  = 6'h0A;
  localparam logic [5:0]  OP_AND_IMMEDIATE16   = 6'h36;
  localparam logic [5:0]  OP_CMP_R  = 6'h0F;
  localparam logic [5:0]  OP_CMP_I5 = 6'h13;
  localparam logic [5:0]  OP_CLR1I  = 6'h3E;
  localparam logic [5:0]  OP_EXT    = 6'h3F;
  localparam logic [3:0]  OP_BCOND  = 4'hB;
  localparam logic [1:0]  CLR1I_TOP = 2'h2;
  localparam logic [9:0]  OP_TABLE_CALL  = 10'h008;
  localparam logic [10:0] SUB_BSH   = 11'h342;
  localparam logic [10:0] SUB_BSW   = 11'h340;
  localparam logic [5:0]  SUB_CMOVR = 6'h19;
  localparam logic [5:0]  SUB_CMOVI = 6'h18;
  localparam logic [15:0] HW1_CLR1R = 16'h00E4;
  localparam logic [15:0] HW0_RET   = 16'h07E0;
  localparam logic [15:0] HW1_TABLE_CALL_RETURN = 16'h0144;
  localparam logic [15:0] HW1_DEBUG_RETURN = 16'h0146;

  // ----------------------------------------------------------------
  // Busy cycles after the issue cycle (issue count minus one)
  // ----------------------------------------------------------------
  localparam logic [2:0]  BUSY_BR    = 3'h1;
  localparam logic [2:0]  BUSY_TABLE_CALL = 3'h3;
  localparam logic [2:0]  BUSY_BIT_CLEAR  = 3'h2;
  localparam logic [2:0]  BUSY_RET   = 3'h2;

  // ----------------------------------------------------------------
  // Software port map
  // ----------------------------------------------------------------
  localparam logic [5:0]  SW_PSW   = 6'h20;
  localparam logic [5:0]  SW_PC    = 6'h21;
  localparam logic [5:0]  SW_TABLE_CALL_RETURN_PC  = 6'h22;
  localparam logic [5:0]  SW_TABLE_CALL_SAVED_STATUS = 6'h23;
  localparam logic [5:0]  SW_TABLE_CALL_BASE  = 6'h24;
  localparam logic [5:0]  SW_DEBUG_RETURN_PC  = 6'h25;
  localparam logic [5:0]  SW_DEBUG_SAVED_STATUS = 6'h26;

  typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_BSH, ALU_BSW} cec_alu_op_t;
  typedef enum logic [2:0] {ST_RUN, ST_CT_ADDR, ST_CT_DATA, ST_BC_ADDR, ST_BC_DATA} cec_state_t;
endpackage : cec_pkg

//--- rtl/cec_alu_if.sv
interface cec_alu_if;
  import cec_pkg::*;
  logic [31:0] a;
  logic [31:0] b;
  cec_alu_op_t op;
  logic [31:0] res;
  logic        cy;
  logic        ov;
  modport ctl (output a, b, op, input res, cy, ov);
  modport alu (input a, b, op, output res, cy, ov);
endinterface : cec_alu_if

//--- rtl/cec_cond_eval.sv
module cec_cond_eval
  import cec_pkg::*;
(
  // Condition code and flags
  input  wire logic [3:0] cond,
  input  wire logic [4:0] flags,
  // Verdict
  output logic            take
);
  logic lt;

  // Shared four-bit condition decode
  always_comb begin
    lt = flags[FLG_S] ^ flags[FLG_OV];
    case (cond[2:0])
      3'h0:    take = flags[FLG_OV];
      3'h1:    take = flags[FLG_CY];
      3'h2:    take = flags[FLG_Z];
      3'h3:    take = flags[FLG_CY] | flags[FLG_Z];
      3'h4:    take = flags[FLG_S];
      3'h6:    take = lt;
      3'h7:    take = lt | flags[FLG_Z];
      default: take = 1'b1;
    endcase
    if (cond == 4'hD) begin
      take = flags[FLG_SAT];
    end else if (cond[3] && cond[2:0] != 3'h5) begin
      take = ~take;
    end
  end
endmodule : cec_cond_eval

//--- rtl/cec_alu.sv
module cec_alu
  import cec_pkg::*;
(
  // Operands and result
  cec_alu_if.alu io
);
  logic [32:0] sum;

  // Add, subtract, logic and byte swaps
  always_comb begin
    sum    = 33'h0_0000_0000;
    io.cy  = 1'b0;
    io.ov  = 1'b0;
    io.res = 32'h0000_0000;
    case (io.op)
      ALU_ADD: begin
        sum    = {1'b0, io.a} + {1'b0, io.b};
        io.res = sum[31:0];
        io.cy  = sum[32];
        io.ov  = (io.a[31] == io.b[31]) && (sum[31] != io.a[31]);
      end
      ALU_SUB: begin
        sum    = {1'b0, io.a} - {1'b0, io.b};
        io.res = sum[31:0];
        io.cy  = sum[32];
        io.ov  = (io.a[31] != io.b[31]) && (sum[31] != io.a[31]);
      end
      ALU_AND: io.res = io.a & io.b;
      ALU_BSH: begin
        io.res = {io.a[23:16], io.a[31:24], io.a[7:0], io.a[15:8]};
        io.cy  = (io.a[7:0] == 8'h00) || (io.a[15:8] == 8'h00);
      end
      default: begin
        io.res = {io.a[7:0], io.a[15:8], io.a[23:16], io.a[31:24]};
        io.cy  = (io.a[7:0] == 8'h00) || (io.a[15:8] == 8'h00) ||
                 (io.a[23:16] == 8'h00) || (io.a[31:24] == 8'h00);
      end
    endcase
  end
endmodule : cec_alu

//--- verif/cec_exec_assertions.sv
module cec_exec_assertions
  import cec_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Instruction port
  input wire logic        insnValid,
  input wire logic [31:0] insn,
  input wire logic        insnReady,
  input wire logic [31:0] pc,
  // Memory port
  input wire logic        memRd,
  input wire logic        memWr,
  input wire logic        memByte,
  input wire logic [31:0] memAddr,
  input wire logic [15:0] memWdata,
  input wire logic [15:0] memRdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        take, isAlu, isBr, isCt, isClr, isClrI, isRet, isCmov, isSwap, memTake;
  logic [31:0] brDisp;
  logic [7:0]  clrMask;
  // Decode of the instruction on offer
  assign take    = insnValid && insnReady;
  assign isAlu   = insn[10:5] inside {OP_ADD_R, OP_ADD_I5, OP_AND_R, OP_CMP_R, OP_CMP_I5};
  assign isBr    = insn[10:7] == OP_BCOND;
  assign isCt    = insn[15:6] == OP_TABLE_CALL;
  assign isClr   = insn[10:5] == OP_EXT && insn[31:16] == HW1_CLR1R;
  assign isClrI  = insn[15:14] == CLR1I_TOP && insn[10:5] == OP_CLR1I;
  assign isRet   = insn[15:0] == HW0_RET && insn[31:16] inside {HW1_TABLE_CALL_RETURN, HW1_DEBUG_RETURN};
  assign isCmov  = insn[10:5] == OP_EXT && insn[26:21] inside {SUB_CMOVR, SUB_CMOVI};
  assign isSwap  = insn[10:5] == OP_EXT && insn[26:16] inside {SUB_BSH, SUB_BSW};
  assign memTake = take && (isCt || isClr || isClrI);
  assign brDisp  = {{23{insn[15]}}, insn[15:11], insn[6:4], 1'b0};
  assign clrMask = ~(8'h01 << insn[13:11]);

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Multi-cycle walks on the memory port
  sequence s_ct_walk;
    (memRd && !memByte && !insnReady) ##1 !insnReady [*2] ##1 insnReady;
  endsequence
  sequence s_clr_walk;
    (memRd && memByte) ##1 !memWr ##1 (memWr && memByte && memAddr == $past(memAddr, 2));
  endsequence

  a_alu_single: assert property (take && isAlu |=> insnReady && pc == $past(pc) + 32'h2)
    else $error("alu op not single cycle");
  a_branch_always: assert property (take && isBr && insn[3:0] == 4'h5 |=>
    !insnReady && pc == $past(pc) + $past(brDisp) ##1 insnReady)
    else $error("always branch wrong");
  a_table_call_walk: assert property (take && isCt |=> s_ct_walk)
    else $error("table call walk wrong");
  a_clr_walk: assert property (take && (isClr || isClrI) |=> s_clr_walk)
    else $error("bit clear walk wrong");
  a_clr_value: assert property (take && isClrI |-> ##3
    memWdata == ($past(memRdata) & {8'h00, $past(clrMask, 3)}))
    else $error("bit clear data wrong");
  a_ret_walk: assert property (take && isRet |=> !insnReady [*2] ##1 insnReady)
    else $error("return timing wrong");
  a_cond_move_one: assert property (take && isCmov |=> insnReady && pc == $past(pc) + 32'h4)
    else $error("cond_move timing wrong");
  a_swap_one: assert property (take && isSwap |=> insnReady && pc == $past(pc) + 32'h4)
    else $error("swap timing wrong");
  a_mem_cause: assert property (memRd |-> $past(memTake))
    else $error("stray memory read");
endmodule : cec_exec_assertions

bind cec_exec cec_exec_assertions i_chk (.clk(clk), .srst(srst), .insnValid(insnValid),
  .insn(insn), .insnReady(insnReady), .pc(pc), .memRd(memRd), .memWr(memWr),
  .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));

//--- verif/cec_mem_model.sv
module cec_mem_model (
  // Clock
  input wire logic        clk,
  // Access from the core
  input wire logic        memRd,
  input wire logic        memWr,
  input wire logic        memByte,
  input wire logic [31:0] memAddr,
  input wire logic [15:0] memWdata,
  output logic     [15:0] memRdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:511];
  logic [8:0] a;
  assign a = memAddr[8:0];
  initial memRdata = 16'h0000;
  // Answer one cycle after the read strobe; scramble when idle
  always @(posedge clk) begin
    if (memRd) begin
      memRdata <= memByte ? {8'h00, mem[a]} : {mem[a + 9'h1], mem[a]};
    end else begin
      memRdata <= ~memRdata;
    end
    if (memWr) begin
      mem[a] <= memWdata[7:0];
    end
  end
endmodule : cec_mem_model

//--- verif/tb.sv
module tb;
  import cec_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, srst, insnValid, insnReady, memRd, memWr, memByte, swWr, swRd, rdy1;
  logic [31:0] insn, pc, memAddr, swWdata, swRdata, expPc, rd;
  logic [15:0] memWdata, memRdata;
  logic [5:0]  swAddr;
  int          badCount, testsRun;

  // Core and memory
  cec_exec i_dut (.clk(clk), .srst(srst), .insnValid(insnValid), .insn(insn),
    .insnReady(insnReady), .pc(pc), .memRd(memRd), .memWr(memWr), .memByte(memByte),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .swAddr(swAddr),
    .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata));
  cec_mem_model i_mem (.clk(clk), .memRd(memRd), .memWr(memWr), .memByte(memByte),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));

  // Clock at 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic swW(input logic [5:0] a, input logic [31:0] d);
    swWr    <= 1'b1;
    swAddr  <= a;
    swWdata <= d;
    @(posedge clk);
    swWr <= 1'b0;
    @(posedge clk);
  endtask : swW

  // Read data appears in the cycle after the strobe and holds until the next read
  task automatic chkR(input string what, input logic [5:0] a, input logic [31:0] exp);
    swRd   <= 1'b1;
    swAddr <= a;
    @(posedge clk);
    swRd <= 1'b0;
    @(negedge clk);
    rd = swRdata;
    @(posedge clk);
    check(what, exp, rd);
  endtask : chkR

  // Offer until taken; valid stays up for back-to-back use
  task automatic issue(input logic [31:0] w);
    int n;
    n = 0;
    insnValid <= 1'b1;
    insn      <= w;
    @(negedge clk);
    while (insnReady !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) badCount++;
    @(posedge clk);
  endtask : issue

  // Withdraw and wait until the core is free again
  task automatic done;
    int n;
    n = 0;
    insnValid <= 1'b0;
    @(negedge clk);
    rdy1 = insnReady;
    while (insnReady !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) badCount++;
    @(posedge clk);
  endtask : done

  task automatic endTest(input string name);
    check("pc", expPc, pc);
    $display("test %s finished", name);
  endtask : endTest

  // Condition table: zero0 sign1 wrap2 carry3 clamp4
  function automatic logic condOk(input logic [3:0] c, input logic [4:0] f);
    logic [7:0] b;
    b = {(f[1] ^ f[2]) | f[0], f[1] ^ f[2], 1'b1, f[1], f[3] | f[0], f[0], f[3], f[2]};
    condOk = (c == 4'hD) ? f[4] : b[c[2:0]] ^ c[3];
  endfunction : condOk

  task automatic tReset;
    check("ready", 32'h1, {31'h0, insnReady});
    chkR("unmapped", 6'h3F, 32'h0);
    swW(6'h00, 32'h5);
    chkR("gr0", 6'h00, 32'h0);
    endTest("reset");
  endtask : tReset

  // Dependent add, add, and, compare back to back
  task automatic tAlu;
    swW(6'h01, 32'h7FFF_FFFF);
    swW(6'h02, 32'h1);
    swW(6'h04, 32'h8000_0000);
    issue({16'h0, 5'h2, OP_ADD_R, 5'h1});
    issue({16'h0, 5'h4, OP_ADD_R, 5'h2});
    issue({16'h0, 5'h2, OP_AND_R, 5'h1});
    issue({16'h0, 5'h4, OP_CMP_I5, 5'h1F});
    done;
    expPc += 32'h8;
    chkR("and", 6'h02, 32'h0);
    chkR("add", 6'h04, 32'h0);
    chkR("psw", SW_PSW, 32'h8);
    // Wide immediates, short immediate and register compare, dependent chain
    issue({16'hFFFF, 5'h5, OP_ADD_IMMEDIATE16, 5'h1});
    issue({16'h8001, 5'h6, OP_AND_IMMEDIATE16, 5'h5});
    issue({16'h0, 5'h6, OP_ADD_I5, 5'h10});
    issue({16'h0, 5'h6, OP_CMP_R, 5'h5});
    done;
    expPc += 32'hC;
    chkR("add16", 6'h05, 32'h7FFF_FFFE);
    chkR("and16 add5", 6'h06, 32'h0000_7FF0);
    chkR("psw cmp", SW_PSW, 32'hA);
    endTest("alu");
  endtask : tAlu

  // Every code against every flag pattern, move then branch
  task automatic tCond;
    logic t;
    swW(6'h01, 32'hA);
    swW(6'h02, 32'hB);
    for (int f = 0; f < 32; f++) begin
      for (int c = 0; c < 16; c++) begin
        t = condOk(4'(c), 5'(f));
        swW(SW_PSW, 32'(f));
        issue({5'h3, SUB_CMOVR, 4'(c), 1'b0, 5'h2, OP_EXT, 5'h1});
        issue({16'h0, 5'h0, OP_BCOND, 3'h4, 4'(c)});
        done;
        expPc += t ? 32'hC : 32'h6;
        check("busy", {31'h0, !t}, {31'h0, rdy1});
        chkR("cond_move", 6'h03, t ? 32'hA : 32'hB);
        chkR("psw", SW_PSW, 32'(f));
      end
    end
    endTest("cond");
  endtask : tCond

  task automatic tSwap;
    swW(6'h02, 32'h1122_3344);
    swW(SW_PSW, 32'h4);
    issue({5'h3, SUB_BSW, 5'h2, OP_EXT, 5'h0});
    issue({5'h4, SUB_BSH, 5'h2, OP_EXT, 5'h0});
    done;
    expPc += 32'h8;
    chkR("bsw", 6'h03, 32'h4433_2211);
    chkR("bsh", 6'h04, 32'h2211_4433);
    chkR("psw", SW_PSW, 32'h0);
    endTest("swap");
  endtask : tSwap

  task automatic tCall;
    logic [31:0] ret;
    ret = expPc + 32'h2;
    swW(SW_TABLE_CALL_BASE, 32'h100);
    swW(SW_PSW, 32'h1F);
    issue({16'h0, OP_TABLE_CALL, 6'h3});
    done;
    check("entry", 32'h140, pc);
    chkR("table_call_return_pc", SW_TABLE_CALL_RETURN_PC, ret);
    chkR("table_call_saved_status", SW_TABLE_CALL_SAVED_STATUS, 32'h1F);
    swW(SW_PSW, 32'h0);
    issue({HW1_TABLE_CALL_RETURN, HW0_RET});
    done;
    check("table_call_return", ret, pc);
    chkR("psw", SW_PSW, 32'h1F);
    swW(SW_DEBUG_RETURN_PC, 32'h200);
    swW(SW_DEBUG_SAVED_STATUS, 32'h11);
    issue({HW1_DEBUG_RETURN, HW0_RET});
    done;
    expPc = 32'h200;
    chkR("debug_saved_status", SW_PSW, 32'h11);
    endTest("call");
  endtask : tCall

  // Clear a set bit, then an already clear one
  task automatic tClr;
    swW(6'h01, 32'h20);
    for (int k = 0; k < 2; k++) begin
      swW(SW_PSW, 32'h0);
      issue({16'h0010, CLR1I_TOP, k ? 3'h1 : 3'h5, OP_CLR1I, 5'h1});
      done;
      expPc += 32'h4;
      chkR("psw", SW_PSW, 32'(k));
      check("byte", 32'h85, {24'h0, i_mem.mem[9'h30]});
    end
    // Register form on the top bit of the same byte
    swW(6'h01, 32'h30);
    swW(6'h02, 32'h7);
    issue({HW1_CLR1R, 5'h2, OP_EXT, 5'h1});
    done;
    expPc += 32'h4;
    chkR("psw reg", SW_PSW, 32'h0);
    check("byte reg", 32'h05, {24'h0, i_mem.mem[9'h30]});
    endTest("clr");
  endtask : tClr

  task automatic closeOut;
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : closeOut

  // Main sequence
  initial begin
    srst      = 1'b1;
    insnValid = 1'b0;
    insn      = 32'h0;
    swWr      = 1'b0;
    swRd      = 1'b0;
    swAddr    = 6'h0;
    swWdata   = 32'h0;
    expPc     = 32'h0;
    badCount  = 0;
    testsRun  = 0;
    i_mem.mem[9'h106] = 8'h40;
    i_mem.mem[9'h107] = 8'h00;
    i_mem.mem[9'h30]  = 8'hA5;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    tReset;
    tAlu;
    tCond;
    tSwap;
    tCall;
    tClr;
    closeOut;
  end

  // Tests need about 5000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    badCount++;
    closeOut;
  end
endmodule : tb
